// ---- src/imf_pkg.sv ----
// constants, types and helpers for the line multiframe and overhead framer
// What this block does
// - a multiframe is eight consecutive basic frames; overhead placed by frame index
// - inverted sync word marks multiframe frame one; receiver finds multiframes by it
// - alignment method is free; here search, verify on repeat, drop after misses
// - transmit frames follow received frames, starting 60 plus or minus 2 quats later
// - overhead is the last three quats, sign then magnitude, bits 235 to 240
// - overhead channel runs at 4 kbit/s, six bits per frame
// - 48 overhead bits per multiframe, six per frame over eight frames
// - 24 bits per multiframe form the operations channel at 2 kbit/s
// - twelve check bits go in bits five and six of frames 3 to 8
// - frame 1 bits five, six are 1; frame 2 bit five 1, six far-end error
// - bits one to three: address, flag plus info, info three to eight
// - received bit four: activation, deactivation, ones, unit-only-activated, alarm indication
// - sent bit four: activation, power status, test mode, cold start, 1, activity, 1
// - everything except the sync word is scrambled and descrambled
// - a frame is 120 quats: sync 1-9, payload 10-117, overhead 118-120
// - sync word +3 +3 -3 -3 -3 +3 -3 +3 +3; inverted is its complement
// - bit pairs map 10 +3, 11 +1, 01 -1, 00 -3, and back
package imf_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int SYM_RATE_BAUD = 80_000;
	localparam int SYM_DIV = CLK_HZ / SYM_RATE_BAUD;
	localparam int DIV_W = 11;
	localparam real FRAME_MS = 1.5;
	localparam int QUATS_PER_FRAME = int'(FRAME_MS * SYM_RATE_BAUD / 1000.0);
	localparam real TX_OFFSET_MS = 0.75;
	localparam int TX_OFFSET_QUATS = int'(TX_OFFSET_MS * SYM_RATE_BAUD / 1000.0);
	localparam int TX_OFFSET_TOL = 2;
	localparam int FRAMES_PER_MF = 8;
	localparam logic [6:0] POS_FIRST = 7'h01;
	localparam logic [6:0] POS_SYNC_LAST = 7'h09;
	localparam logic [6:0] POS_PAY_FIRST = 7'h0a;
	localparam logic [6:0] POS_PAY_LAST = 7'h75;
	localparam logic [6:0] POS_OVH_FIRST = 7'h76;
	localparam logic [6:0] POS_OVH_MID = 7'h77;
	localparam logic [6:0] POS_LAST = 7'(QUATS_PER_FRAME);
	localparam logic [6:0] POS_TX_RELOCK = 7'(TX_OFFSET_QUATS);
	// sign bit first in each pair; inverted word flips every sign
	localparam logic [17:0] SYNC_WORD = 18'h2_808a;
	localparam logic [17:0] SYNC_INV_MASK = 18'h2_aaaa;
	localparam logic [1:0] QUAT_ONES = 2'h3;
	localparam logic [2:0] FRAME_1 = 3'h0;
	localparam logic [2:0] FRAME_2 = 3'h1;
	localparam logic [2:0] FRAME_3 = 3'h2;
	localparam logic [2:0] FRAME_4 = 3'h3;
	localparam logic [2:0] FRAME_5 = 3'h4;
	localparam logic [2:0] FRAME_6 = 3'h5;
	localparam logic [2:0] FRAME_7 = 3'h6;
	localparam logic [2:0] FRAME_8 = 3'h7;
	localparam logic [11:0] RESET_WORD12 = 12'h000;

	typedef enum logic [1:0] {
		ALIGN_SEARCH = 2'b00,
		ALIGN_VERIFY = 2'b01,
		ALIGN_LOCKED = 2'b11
	} imf_align_state_type;

	// quat at position pos (1..9) of an 18-bit word, first quat in the top bits
	function automatic logic [1:0] imf_word_quat(input logic [17:0] word, input logic [6:0] pos);
		int idx;
		idx = 17 - 2 * (int'(pos) - 1);
		return word[idx -: 2];
	endfunction
endpackage

// ---- src/imf_align_if.sv ----
// carrier between the framer and its receive aligner
`timescale 1ns/1ps
`default_nettype none
interface imf_align_if;
	logic sym_en;
	logic [1:0] quat;
	logic [6:0] pos;
	logic [2:0] frame;
	logic locked;
	logic mf_start;
	modport aligner (input sym_en, input quat, output pos, output frame, output locked,
		output mf_start);
	modport framer (output sym_en, output quat, input pos, input frame, input locked,
		input mf_start);
endinterface
`default_nettype wire

// ---- src/imf_rx_align.sv ----
// receive frame and multiframe alignment on raw line quats
`timescale 1ns/1ps
`default_nettype none
module imf_rx_align
	import imf_pkg::*;
#(
	parameter int MISS_LIMIT = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// link to framer
	imf_align_if.aligner al
);
	initial begin
		if (MISS_LIMIT < 1 || MISS_LIMIT > 7) $error("imf_rx_align: MISS_LIMIT out of range");
	end

	imf_align_state_type state;
	logic [15:0] hist;
	logic [2:0] misses;
	logic [17:0] window;
	logic hit_norm;
	logic hit_inv;
	logic [6:0] next_pos;
	logic at_check;

	// sync word is never scrambled, so the raw quat window is compared
	assign window = {hist, al.quat};
	assign hit_norm = (window == SYNC_WORD);
	assign hit_inv = (window == (SYNC_WORD ^ SYNC_INV_MASK));
	assign next_pos = (al.pos == POS_LAST) ? POS_FIRST : al.pos + 7'h01;
	assign at_check = (state == ALIGN_SEARCH) ? (hit_norm || hit_inv) : (next_pos == POS_SYNC_LAST);

	always_ff @(posedge clk) begin
		if (srst) hist <= '0;
		else if (al.sym_en) hist <= window[15:0];
	end

	// search, then one repeat to verify; a lock survives isolated misses
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= ALIGN_SEARCH;
			misses <= '0;
			al.pos <= POS_FIRST;
		end else if (al.sym_en) begin
			al.pos <= at_check ? POS_SYNC_LAST : next_pos;
			if (state == ALIGN_SEARCH) begin
				if (at_check) state <= ALIGN_VERIFY;
			end else if (at_check) begin
				if (hit_norm || hit_inv) begin
					state <= ALIGN_LOCKED;
					misses <= '0;
				end else if (state == ALIGN_VERIFY || misses == 3'(MISS_LIMIT - 1)) begin
					state <= ALIGN_SEARCH;
					misses <= '0;
				end else begin
					misses <= misses + 3'h1;
				end
			end
		end
	end

	// frame index moves at each sync check; inverted word forces frame one
	always_ff @(posedge clk) begin
		if (srst) begin
			al.frame <= FRAME_1;
			al.mf_start <= 1'b0;
		end else begin
			al.mf_start <= al.sym_en && at_check && hit_inv && state != ALIGN_SEARCH;
			if (al.sym_en && at_check)
				al.frame <= hit_inv ? FRAME_1 : al.frame + 3'h1;
		end
	end

	assign al.locked = (state == ALIGN_LOCKED);

	chk_frame_reset: assert property (@(posedge clk) disable iff (srst)
		al.sym_en && at_check && hit_inv |=> al.frame == FRAME_1)
		else $error("frame index not reset by inverted word");
	chk_pos_wrap: assert property (@(posedge clk) disable iff (srst)
		al.sym_en && al.pos == POS_LAST && !at_check |=> al.pos == POS_FIRST)
		else $error("quat position did not wrap after 120");
	chk_lock_cause: assert property (@(posedge clk) disable iff (srst)
		$rose(al.locked) |-> $past(hit_norm || hit_inv) && $past(state) == ALIGN_VERIFY)
		else $error("lock without verified sync word");
	cov_lock: cover property (@(posedge clk) disable iff (srst) $rose(al.locked));
	cov_mf: cover property (@(posedge clk) disable iff (srst) al.mf_start && al.locked);
endmodule
`default_nettype wire

// ---- src/imf_framer.sv ----
// multiframe and overhead framer at the network termination end of the loop
`timescale 1ns/1ps
`default_nettype none
module imf_framer
	import imf_pkg::*;
#(
	parameter int MISS_LIMIT = 2,
	parameter int SYM_CLKS = SYM_DIV
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// line side, sign bit high, one quat per symbol tick
	input wire logic [1:0] rx_quat_pin,
	output logic [1:0] tx_quat,
	output logic sym_tick,
	// scrambler keystreams from the external scramblers
	input wire logic [1:0] rx_descr_mask,
	input wire logic [1:0] tx_scr_mask,
	// payload
	input wire logic [1:0] tx_payload_bits,
	output logic tx_payload_take,
	output logic [1:0] rx_payload_bits,
	output logic rx_payload_valid,
	// transmit overhead
	input wire logic [11:0] tx_eoc_word,
	input wire logic [11:0] tx_crc,
	input wire logic tx_far_end_block_error,
	input wire logic tx_activation_bit,
	input wire logic tx_power_status_one,
	input wire logic tx_power_status_two,
	input wire logic tx_test_mode_indicator,
	input wire logic tx_cold_start_only,
	input wire logic tx_activity_indicator_bit,
	// receive overhead
	output logic [11:0] rx_eoc_word,
	output logic rx_eoc_valid,
	output logic [11:0] rx_crc,
	output logic rx_crc_valid,
	output logic rx_far_end_block_error,
	output logic activation_bit,
	output logic deactivation_bit,
	output logic unit_only_activated_bit,
	output logic alarm_indication_bit,
	// status
	output logic rx_frame_locked,
	output logic rx_multiframe_start
);
	initial begin
		// three or more keeps the tick a lone pulse between quats
		if (SYM_CLKS < 3 || SYM_CLKS >= (1 << DIV_W)) $error("imf_framer: divider out of range");
	end

	imf_align_if al ();
	logic [DIV_W-1:0] div_cnt;
	logic [1:0] pin_meta;
	logic [1:0] pin_sync;
	logic [1:0] rx_bits;
	logic [3:0] ovh_hold;
	logic [5:0] rx_m;
	logic [6:0] tx_pos;
	logic [2:0] tx_frame;
	logic [6:0] next_tx_pos;
	logic [2:0] next_tx_frame;
	logic [1:0] next_plain;
	logic next_is_word;
	logic [1:0] tx_plain;
	logic [11:0] eoc_hold;
	logic [11:0] crc_hold;
	logic [5:0] tx_m;
	logic relock;

	// symbol rate from a divider; one clock everywhere
	always_ff @(posedge clk) begin
		if (srst) begin
			div_cnt <= '0;
			al.sym_en <= 1'b0;
		end else begin
			al.sym_en <= (div_cnt == DIV_W'(SYM_CLKS - 1));
			div_cnt <= (div_cnt == DIV_W'(SYM_CLKS - 1)) ? '0 : div_cnt + 1'b1;
		end
	end

	// the line pin is asynchronous to clk
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= rx_quat_pin;
			pin_sync <= pin_meta;
		end
	end
	assign al.quat = pin_sync;

	imf_rx_align #(.MISS_LIMIT(MISS_LIMIT)) u_align (
		.clk(clk),
		.srst(srst),
		.al(al.aligner)
	);

	// position the aligner reports is the one of the quat just taken
	assign rx_bits = pin_sync ^ rx_descr_mask;

	always_ff @(posedge clk) begin
		if (srst) begin
			rx_payload_bits <= '0;
			rx_payload_valid <= 1'b0;
			ovh_hold <= '0;
		end else begin
			rx_payload_valid <= 1'b0;
			if (al.sym_en && al.locked) begin
				if (al.pos >= POS_PAY_FIRST - 7'h01 && al.pos < POS_PAY_LAST) begin
					rx_payload_bits <= rx_bits;
					rx_payload_valid <= 1'b1;
				end
				if (al.pos >= POS_PAY_LAST && al.pos < POS_LAST - 7'h01)
					ovh_hold <= {ovh_hold[1:0], rx_bits};
			end
		end
	end
	assign rx_m = {ovh_hold, rx_bits};

	// overhead routing by frame index, done when the last quat arrives
	always_ff @(posedge clk) begin
		if (srst) begin
			rx_eoc_word <= RESET_WORD12;
			rx_eoc_valid <= 1'b0;
			rx_crc <= RESET_WORD12;
			rx_crc_valid <= 1'b0;
			rx_far_end_block_error <= 1'b0;
			activation_bit <= 1'b0;
			deactivation_bit <= 1'b0;
			unit_only_activated_bit <= 1'b0;
			alarm_indication_bit <= 1'b0;
		end else begin
			rx_eoc_valid <= 1'b0;
			rx_crc_valid <= 1'b0;
			if (al.sym_en && al.locked && al.pos == POS_LAST - 7'h01) begin
				rx_eoc_word <= {rx_eoc_word[8:0], rx_m[5:3]};
				rx_eoc_valid <= (al.frame[1:0] == FRAME_4[1:0]);
				if (al.frame >= FRAME_3)
					rx_crc <= {rx_crc[9:0], rx_m[1:0]};
				rx_crc_valid <= (al.frame == FRAME_8);
				unique case (al.frame)
					FRAME_1: activation_bit <= rx_m[2];
					FRAME_2: begin
						deactivation_bit <= rx_m[2];
						rx_far_end_block_error <= rx_m[0];
					end
					FRAME_7: unit_only_activated_bit <= rx_m[2];
					FRAME_8: alarm_indication_bit <= rx_m[2];
					default: ;
				endcase
			end
		end
	end

	// transmit timing slaved to the received frame with a fixed offset
	assign relock = al.locked && al.pos == POS_TX_RELOCK;
	always_comb begin
		if (relock) begin
			next_tx_pos = POS_FIRST;
			next_tx_frame = al.frame;
		end else if (tx_pos == POS_LAST) begin
			next_tx_pos = POS_FIRST;
			next_tx_frame = tx_frame + 3'h1;
		end else begin
			next_tx_pos = tx_pos + 7'h01;
			next_tx_frame = tx_frame;
		end
	end

	// sent overhead bits, m1 first
	always_comb begin
		tx_m[5:3] = eoc_hold[11 - 3 * int'(tx_frame[1:0]) -: 3];
		unique case (tx_frame)
			FRAME_1: tx_m[2] = tx_activation_bit;
			FRAME_2: tx_m[2] = tx_power_status_one;
			FRAME_3: tx_m[2] = tx_power_status_two;
			FRAME_4: tx_m[2] = tx_test_mode_indicator;
			FRAME_5: tx_m[2] = tx_cold_start_only;
			FRAME_6: tx_m[2] = 1'b1;
			FRAME_7: tx_m[2] = tx_activity_indicator_bit;
			FRAME_8: tx_m[2] = 1'b1;
		endcase
		if (tx_frame == FRAME_1) tx_m[1:0] = QUAT_ONES;
		else if (tx_frame == FRAME_2) tx_m[1:0] = {1'b1, tx_far_end_block_error};
		else tx_m[1:0] = crc_hold[11 - 2 * (int'(tx_frame) - 2) -: 2];
	end

	always_comb begin
		next_is_word = (next_tx_pos <= POS_SYNC_LAST);
		if (next_is_word)
			next_plain = imf_word_quat((next_tx_frame == FRAME_1) ?
				(SYNC_WORD ^ SYNC_INV_MASK) : SYNC_WORD, next_tx_pos);
		else if (next_tx_pos <= POS_PAY_LAST)
			next_plain = tx_payload_bits;
		else if (next_tx_pos == POS_OVH_FIRST)
			next_plain = tx_m[5:4];
		else if (next_tx_pos == POS_OVH_MID)
			next_plain = tx_m[3:2];
		else
			next_plain = tx_m[1:0];
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			tx_pos <= POS_LAST;
			tx_frame <= FRAME_8;
			tx_plain <= '0;
			tx_quat <= '0;
			tx_payload_take <= 1'b0;
			sym_tick <= 1'b0;
		end else begin
			sym_tick <= al.sym_en;
			tx_payload_take <= al.sym_en && !next_is_word && next_tx_pos <= POS_PAY_LAST;
			if (al.sym_en) begin
				tx_pos <= next_tx_pos;
				tx_frame <= next_tx_frame;
				tx_plain <= next_plain;
				tx_quat <= next_is_word ? next_plain : next_plain ^ tx_scr_mask;
			end
		end
	end

	// eoc operand held per half multiframe, check bits per multiframe, so a change mid-frame cannot tear a field
	always_ff @(posedge clk) begin
		if (srst) begin
			eoc_hold <= RESET_WORD12;
			crc_hold <= RESET_WORD12;
		end else if (al.sym_en && next_tx_pos == POS_FIRST) begin
			if (next_tx_frame[1:0] == FRAME_1[1:0]) eoc_hold <= tx_eoc_word;
			if (next_tx_frame == FRAME_1) crc_hold <= tx_crc;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rx_frame_locked <= 1'b0;
			rx_multiframe_start <= 1'b0;
		end else begin
			rx_frame_locked <= al.locked;
			rx_multiframe_start <= al.mf_start;
		end
	end

	chk_sym_single: assert property (@(posedge clk) disable iff (srst)
		al.sym_en |=> !al.sym_en ##1 !al.sym_en)
		else $error("symbol tick longer than one cycle");
	chk_tx_offset: assert property (@(posedge clk) disable iff (srst)
		al.sym_en && relock |=> tx_pos == POS_FIRST && tx_frame == $past(al.frame))
		else $error("transmit frame not restarted at offset");
	chk_inv_word: assert property (@(posedge clk) disable iff (srst)
		tx_frame == FRAME_1 && tx_pos <= POS_SYNC_LAST |->
			tx_quat == imf_word_quat(SYNC_WORD ^ SYNC_INV_MASK, tx_pos))
		else $error("frame one does not carry inverted sync word");
	chk_norm_word: assert property (@(posedge clk) disable iff (srst)
		tx_frame != FRAME_1 && tx_pos <= POS_SYNC_LAST |-> tx_quat == imf_word_quat(SYNC_WORD, tx_pos))
		else $error("sync word quat wrong");
	chk_frame1_ones: assert property (@(posedge clk) disable iff (srst)
		tx_frame == FRAME_1 && tx_pos == POS_LAST |-> tx_plain == QUAT_ONES)
		else $error("frame one bits five and six not ones");
	chk_m4_const: assert property (@(posedge clk) disable iff (srst)
		(tx_frame == FRAME_6 || tx_frame == FRAME_8) && tx_pos == POS_OVH_MID |-> tx_plain[0])
		else $error("constant bit four not one");
	chk_take_window: assert property (@(posedge clk) disable iff (srst)
		tx_payload_take |-> tx_pos >= POS_PAY_FIRST && tx_pos <= POS_PAY_LAST)
		else $error("payload taken outside payload quats");
	chk_crc_done: assert property (@(posedge clk) disable iff (srst)
		rx_crc_valid |-> $past(al.frame, 1) == FRAME_8 && $past(al.pos, 1) == POS_LAST - 7'h01)
		else $error("check word released off frame eight");
	cov_tx_relock: cover property (@(posedge clk) disable iff (srst) al.sym_en && relock);
	cov_crc: cover property (@(posedge clk) disable iff (srst) rx_crc_valid && rx_eoc_valid);
endmodule
`default_nettype wire

// ---- testbench/imf_line_partner.sv ----
// far-end line transceiver model sending framed quats to the framer
`timescale 1ns/1ps
`default_nettype none
module imf_line_partner
	import imf_pkg::*;
#(
	parameter int SYM_CLKS = SYM_DIV
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// frame content
	input wire logic [1:0] scr_mask,
	input wire logic [11:0] eoc_a,
	input wire logic [11:0] eoc_b,
	input wire logic [11:0] crc,
	input wire logic [4:0] ind,
	// line and position
	output logic [1:0] line_quat,
	output logic [6:0] pos,
	output logic [2:0] frame
);
	int cnt;
	logic [17:0] word;
	logic [5:0] m;

	function automatic logic [5:0] mbits(input int f, input logic [11:0] ea,
		input logic [11:0] eb, input logic [11:0] cw, input logic [7:0] m4v, input logic far_end_block_error);
		logic [11:0] e;
		logic [1:0] c;
		e = (f < 4) ? ea : eb;
		c = (f == 0) ? 2'h3 : (f == 1) ? {1'h1, far_end_block_error} : cw[15 - 2 * f -: 2];
		return {e[11 - 3 * (f % 4) -: 3], m4v[f], c};
	endfunction

	// half a symbol away from the framer tick, so sampling never races
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt <= SYM_CLKS / 2;
		end else begin
			cnt <= (cnt == SYM_CLKS - 1) ? 0 : cnt + 1;
		end
	end

	// start in frame 6 so lock is held before the first inverted word
	always_ff @(posedge clk) begin
		if (srst) begin
			pos <= POS_FIRST;
			frame <= FRAME_6;
		end else if (cnt == SYM_CLKS - 1) begin
			pos <= (pos == POS_LAST) ? POS_FIRST : pos + 7'h01;
			if (pos == POS_LAST) begin
				frame <= frame + 3'h1;
			end
		end
	end

	always_comb begin
		word = (frame == FRAME_1) ? SYNC_WORD ^ SYNC_INV_MASK : SYNC_WORD;
		m = mbits(int'(frame), eoc_a, eoc_b, crc, {ind[4], ind[3], 4'hf, ind[1:0]}, ind[2]);
		if (pos <= POS_SYNC_LAST) begin
			line_quat = word[19 - 2 * int'(pos) -: 2];
		end else if (pos <= POS_PAY_LAST) begin
			line_quat = pos[1:0] ^ scr_mask;
		end else begin
			line_quat = m[241 - 2 * int'(pos) -: 2] ^ scr_mask;
		end
	end
endmodule
`default_nettype wire

// ---- testbench/test_isdn_line_multiframe_overhead_framer.sv ----
// self-checking bench for the multiframe and overhead framer
`timescale 1ns/1ps
`default_nettype none
module test_isdn_line_multiframe_overhead_framer;
	import imf_pkg::*;
	// short symbols keep eleven frames within the run budget; framing is rate independent
	localparam int SYM_CLKS = 16;
	logic clk;
	logic srst = 1'h1;
	logic [1:0] rx_quat_pin, tx_quat, rx_payload_bits;
	logic [1:0] rx_descr_mask = 2'h0, tx_scr_mask = 2'h0, tx_payload_bits = 2'h0;
	logic [11:0] tx_eoc_word = 12'h000, tx_crc = 12'h000, lt_eoc_a = 12'h000;
	logic [11:0] lt_eoc_b = 12'h000, lt_crc = 12'h000, rx_eoc_word, rx_crc;
	logic [6:0] tx_ind = 7'h00, lt_pos;
	logic [4:0] lt_ind = 5'h00, rx_ind;
	logic [2:0] lt_frame;
	logic [5:0] m;
	logic sym_tick, tx_payload_take, rx_payload_valid, rx_eoc_valid, rx_crc_valid;
	logic rx_far_end_block_error, activation_bit, deactivation_bit, unit_only_activated_bit;
	logic alarm_indication_bit, rx_frame_locked, rx_multiframe_start;
	logic armed = 1'h0, stat_done = 1'h0;
	logic [17:0] exp_eoc[$], exp_crc[$];
	logic [1:0] exp_quat[$];
	logic [17:0] tx_hist = 18'h0_0000;
	int tx_k = -1;
	int num_errors = 0;
	int tests_run = 0;

	assign rx_ind = {alarm_indication_bit, unit_only_activated_bit, rx_far_end_block_error,
		deactivation_bit, activation_bit};

	imf_line_partner #(.SYM_CLKS(SYM_CLKS)) imf_line_partner_inst (.clk(clk), .srst(srst),
		.scr_mask(rx_descr_mask),
		.eoc_a(lt_eoc_a), .eoc_b(lt_eoc_b), .crc(lt_crc), .ind(lt_ind),
		.line_quat(rx_quat_pin), .pos(lt_pos), .frame(lt_frame));

	imf_framer #(.MISS_LIMIT(2), .SYM_CLKS(SYM_CLKS)) imf_framer_inst (.clk(clk), .srst(srst),
		.rx_quat_pin(rx_quat_pin), .tx_quat(tx_quat), .sym_tick(sym_tick),
		.rx_descr_mask(rx_descr_mask), .tx_scr_mask(tx_scr_mask),
		.tx_payload_bits(tx_payload_bits), .tx_payload_take(tx_payload_take),
		.rx_payload_bits(rx_payload_bits), .rx_payload_valid(rx_payload_valid),
		.tx_eoc_word(tx_eoc_word), .tx_crc(tx_crc), .tx_far_end_block_error(tx_ind[6]),
		.tx_activation_bit(tx_ind[0]), .tx_power_status_one(tx_ind[1]),
		.tx_power_status_two(tx_ind[2]), .tx_test_mode_indicator(tx_ind[3]),
		.tx_cold_start_only(tx_ind[4]), .tx_activity_indicator_bit(tx_ind[5]),
		.rx_eoc_word(rx_eoc_word), .rx_eoc_valid(rx_eoc_valid), .rx_crc(rx_crc),
		.rx_crc_valid(rx_crc_valid), .rx_far_end_block_error(rx_far_end_block_error),
		.activation_bit(activation_bit), .deactivation_bit(deactivation_bit),
		.unit_only_activated_bit(unit_only_activated_bit),
		.alarm_indication_bit(alarm_indication_bit), .rx_frame_locked(rx_frame_locked),
		.rx_multiframe_start(rx_multiframe_start));

	task automatic compare_word(input string what, input logic [17:0] exp, input logic [17:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic compare_quat(input string what, input logic [1:0] exp, input logic [1:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic results();
		if (num_errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	initial begin
		void'($urandom(43));
		@(posedge clk);
		{tx_eoc_word, tx_crc, tx_ind} <= 31'($urandom);
		{lt_eoc_a, lt_eoc_b, lt_ind} <= 29'($urandom);
		{lt_crc, rx_descr_mask, tx_scr_mask} <= 16'($urandom);
		repeat (2) @(posedge clk);
		srst <= 1'h0;
		exp_eoc.push_back(18'(lt_eoc_a));
		exp_eoc.push_back(18'(lt_eoc_b));
		exp_crc.push_back(18'(lt_crc));
		// transmit overhead of frames 1 to 7; frame 8 falls after the run ends
		for (int f = 0; f < 7; f++) begin
			m = imf_line_partner_inst.mbits(f, tx_eoc_word, tx_eoc_word, tx_crc,
				{1'h1, tx_ind[5], 1'h1, tx_ind[4:0]}, tx_ind[6]);
			for (int i = 2; i >= 0; i--) begin
				exp_quat.push_back(m[2 * i +: 2] ^ tx_scr_mask);
			end
		end
		wait (stat_done === 1'h1);
		compare_word("pending", 18'h0_0000, 18'(exp_eoc.size() + exp_crc.size() + exp_quat.size()));
		results();
	end

	always @(posedge clk) begin
		if (rx_multiframe_start === 1'h1 && !armed) begin
			armed <= 1'h1;
			compare_word("locked", 18'h0_0001, 18'(rx_frame_locked));
		end
		if (armed && rx_eoc_valid === 1'h1) begin
			compare_word("eoc word", exp_eoc.pop_front(), 18'(rx_eoc_word));
		end
		if (armed && rx_crc_valid === 1'h1) begin
			compare_word("check bits", exp_crc.pop_front(), 18'(rx_crc));
		end
		if (armed && rx_payload_valid === 1'h1) begin
			compare_quat("rx payload", lt_pos[1:0], rx_payload_bits);
		end
		if (tx_payload_take === 1'h1) begin
			compare_quat("tx payload", tx_payload_bits ^ tx_scr_mask, tx_quat);
			tx_payload_bits <= 2'($urandom);
		end
	end

	// levels hold until the next multiframe, so one look after the last frame sees all
	always @(posedge clk) begin
		if (armed && rx_crc_valid === 1'h1) begin
			repeat (2) @(posedge clk);
			compare_word("indicators", 18'(lt_ind), 18'(rx_ind));
			stat_done <= 1'h1;
		end
	end

	always @(posedge clk) begin
		if (sym_tick === 1'h1) begin
			tx_hist = {tx_hist[15:0], tx_quat};
			tx_k = (tx_k < 0) ? tx_k : tx_k + 1;
			if (tx_k < 0 && armed && tx_hist === (SYNC_WORD ^ SYNC_INV_MASK)) begin
				tx_k = 9;
				compare_word("tx offset", 18'h0_0045, 18'(lt_pos));
			end else if (tx_k == 9) begin
				compare_word("tx sync", SYNC_WORD, tx_hist);
			end
			if (tx_k >= 118 && exp_quat.size() > 0) begin
				compare_quat("tx overhead", exp_quat.pop_front(), tx_quat);
			end
			tx_k = (tx_k == 120) ? 0 : tx_k;
		end
	end

	// eleven frames are needed; two spare frames of margin
	initial begin
		repeat (13 * QUATS_PER_FRAME * SYM_CLKS) @(posedge clk);
		num_errors++;
		results();
	end
endmodule
`default_nettype wire
